// file: common/bacf_cfg.svh
/*
  constants for the broadcast action filter: key width, defaults, slot number.
  assumes inclusion by bare name from the package and the design modules.
*/
`ifndef BACF_CFG_SVH
`define BACF_CFG_SVH

`define BACF_KEY_W 32
`define BACF_AUTH_RST 32'h0000_0000
`define BACF_GROUP_RST 32'h0000_0000
`define BACF_MASK_RST 32'h0000_0000
`define BACF_SLOT_ONE 32'h0000_0001
`define BACF_NUM_SIGNALS 32'h0000_0001
`define BACF_TRIG_FRAME 2'h0
`define BACF_TRIG_ACQ 2'h1
`define BACF_TRIG_LINE 2'h2

`endif

// file: common/bacf_pkg.sv
/*
  types shared by the broadcast action filter modules.
  assumes bacf_cfg.svh on the include path.
*/
`default_nettype none
`include "bacf_cfg.svh"

package bacf_pkg;
  typedef enum logic [2:0] {
    BACF_IDLE = 3'b001,
    BACF_CMP = 3'b010,
    BACF_FIRE = 3'b100
  } bacf_state_t;

  typedef enum logic [1:0] {
    BACF_TSEL_FRAME = `BACF_TRIG_FRAME,
    BACF_TSEL_ACQ = `BACF_TRIG_ACQ,
    BACF_TSEL_LINE = `BACF_TRIG_LINE
  } bacf_trig_sel_t;
endpackage : bacf_pkg

`default_nettype wire

// file: logic/bacf_match.sv
/*
  key and mask comparator for one stored action slot.
  assumes all inputs are registered on mclk; output is combinational.
*/
`timescale 1ns/1ps
`default_nettype none
`include "bacf_cfg.svh"

module bacf_match #(
  parameter int KEY_W = `BACF_KEY_W
) (
  // configured slot
  input wire logic [KEY_W-1:0] cfg_auth,
  input wire logic [KEY_W-1:0] cfg_group,
  input wire logic [KEY_W-1:0] cfg_mask,
  // message fields
  input wire logic [KEY_W-1:0] msg_auth,
  input wire logic [KEY_W-1:0] msg_group,
  input wire logic [KEY_W-1:0] msg_mask,
  // verdict
  output logic hit
);
  wire logic auth_ok;
  wire logic group_ok;
  wire logic mask_ok;

  assign auth_ok = (msg_auth == cfg_auth); // R1
  assign group_ok = (msg_group == cfg_group); // R3
  assign mask_ok = |(msg_mask & cfg_mask); // R4
  assign hit = auth_ok & group_ok & mask_ok; // R5
endmodule : bacf_match

`default_nettype wire

// file: logic/bacf_filter.sv
/*
  broadcast action filter: stores one action slot, checks incoming
  messages, fires the single action signal and routes it to triggers
  and the frame counter reset.
  assumes message and config strobes come from mclk-domain logic.
*/
// Contract
// R1 - fire only when message authorization key equals configured key exactly
// R2 - configured authorization key cannot be read back
// R3 - message group key must equal configured group key
// R4 - message mask and configured mask must share a set bit
// R5 - fire only when key, group and mask all match
// R6 - host reaches many devices with one broadcast message
// R7 - device holds exactly one group key
// R8 - read-only count of action signals reports one
// R9 - each accepted message raises exactly one action signal
// R10 - a new configuration overwrites the old one
// R11 - host sets slot selection to one before programming keys
// R12 - sender uses dotted broadcast destination, all-ones by default
// R13 - action usable as frame, acquisition or line start trigger
// R14 - action as counter reset source resets the frame counter
// R15 - action pulse lasts one cycle, the cycle after the decision; action_pulse is high two cycles after the compare cycle
`timescale 1ns/1ps
`default_nettype none
`include "bacf_cfg.svh"

module bacf_filter
  import bacf_pkg::*;
#(
  parameter int KEY_W = `BACF_KEY_W,
  parameter int CNT_W = 32
) (
  // clock and reset
  input wire logic mclk,
  input wire logic rst,
  // configuration
  input wire logic cfg_we,
  input wire logic [31:0] action_slot_select,
  input wire logic [KEY_W-1:0] cfg_auth_key,
  input wire logic [KEY_W-1:0] cfg_group_key,
  input wire logic [KEY_W-1:0] cfg_subgroup_mask,
  // routing
  input wire logic trigger_from_action,
  input wire logic [1:0] trigger_select,
  input wire logic counter_reset_from_action,
  // incoming message
  input wire logic msg_valid,
  input wire logic [KEY_W-1:0] msg_auth_key,
  input wire logic [KEY_W-1:0] msg_group_key,
  input wire logic [KEY_W-1:0] msg_subgroup_mask,
  // frame counting
  input wire logic frame_done,
  // status
  output logic [31:0] num_action_signals,
  output logic [KEY_W-1:0] group_match_key,
  output logic [KEY_W-1:0] subgroup_mask,
  output logic busy,
  // action outputs
  output logic action_pulse,
  output logic frame_begin_trigger,
  output logic acquisition_begin_trigger,
  output logic line_begin_trigger,
  output logic [CNT_W-1:0] frame_count
);
  // ----------------------------------------
  // helpers
  // ----------------------------------------
  // one decode serves all three trigger outputs; code 3 selects none of them
  function automatic logic route_hit(
    input logic go,
    input logic [1:0] sel,
    input bacf_trig_sel_t code
  );
    return go && (sel == code);
  endfunction : route_hit

  // ----------------------------------------
  // configuration slot
  // ----------------------------------------
  // auth_key feeds only the comparator and no status output, so it can never be read back
  logic [KEY_W-1:0] auth_key;
  wire logic slot_write;
  wire logic [KEY_W-1:0] next_auth_key;
  wire logic [KEY_W-1:0] next_group_key;
  wire logic [KEY_W-1:0] next_mask;

  assign slot_write = cfg_we && (action_slot_select == `BACF_SLOT_ONE); // R11
  assign num_action_signals = `BACF_NUM_SIGNALS; // R8

  // a single slot: every write with slot select one replaces all three fields together; other slot writes are dropped
  assign next_auth_key = slot_write ? cfg_auth_key : auth_key; // R2
  assign next_group_key = slot_write ? cfg_group_key : group_match_key; // R7
  assign next_mask = slot_write ? cfg_subgroup_mask : subgroup_mask; // R10

  always_ff @(posedge mclk) begin
    if (rst) begin
      auth_key <= KEY_W'(`BACF_AUTH_RST);
      group_match_key <= KEY_W'(`BACF_GROUP_RST);
      subgroup_mask <= KEY_W'(`BACF_MASK_RST);
    end else begin
      auth_key <= next_auth_key;
      group_match_key <= next_group_key;
      subgroup_mask <= next_mask;
    end
  end

  // ----------------------------------------
  // message capture and decision
  // ----------------------------------------
  // latching the message decouples the comparator from the sender
  logic [KEY_W-1:0] m_auth;
  logic [KEY_W-1:0] m_group;
  logic [KEY_W-1:0] m_mask;
  bacf_state_t state;
  bacf_state_t next_state;
  wire logic hit;
  wire logic take;

  // messages arriving while busy are dropped, with no sign to the sender
  assign take = (state == BACF_IDLE) && msg_valid;
  assign busy = (state != BACF_IDLE);

  bacf_match #(.KEY_W(KEY_W)) bacf_match_i (
    .cfg_auth(auth_key),
    .cfg_group(group_match_key),
    .cfg_mask(subgroup_mask),
    .msg_auth(m_auth),
    .msg_group(m_group),
    .msg_mask(m_mask),
    .hit(hit)
  );

  always_comb begin
    case (state)
      BACF_IDLE: next_state = take ? BACF_CMP : BACF_IDLE;
      BACF_CMP: next_state = hit ? BACF_FIRE : BACF_IDLE; // R5
      BACF_FIRE: next_state = BACF_IDLE;
      default: next_state = BACF_IDLE;
    endcase
  end

  always_ff @(posedge mclk) begin
    if (rst) begin
      state <= BACF_IDLE;
    end else begin
      state <= next_state;
    end
  end

  // fields move only on a take, so a sender that changes early cannot
  // disturb a compare in progress
  always_ff @(posedge mclk) begin
    if (rst) begin
      m_auth <= '0;
      m_group <= '0;
      m_mask <= '0;
    end else if (take) begin
      m_auth <= msg_auth_key;
      m_group <= msg_group_key;
      m_mask <= msg_subgroup_mask;
    end
  end

  // ----------------------------------------
  // action signal and routing
  // ----------------------------------------
  wire logic fire;
  wire logic trig_go;
  wire logic do_cnt_reset;
  wire logic next_frame_trig;
  wire logic next_acq_trig;
  wire logic next_line_trig;

  // one slot means one action signal: fire is the only source of the pulse, the triggers and the counter reset
  assign fire = (state == BACF_FIRE); // R15
  assign trig_go = fire && trigger_from_action;
  assign do_cnt_reset = fire && counter_reset_from_action; // R14
  assign next_frame_trig = route_hit(trig_go, trigger_select, BACF_TSEL_FRAME); // R13
  assign next_acq_trig = route_hit(trig_go, trigger_select, BACF_TSEL_ACQ); // R13
  assign next_line_trig = route_hit(trig_go, trigger_select, BACF_TSEL_LINE); // R13

  always_ff @(posedge mclk) begin
    if (rst) begin
      action_pulse <= 1'b0;
    end else begin
      action_pulse <= fire; // R9
    end
  end

  // triggers launch on the same edge as the pulse, so they line up with it
  always_ff @(posedge mclk) begin
    if (rst) begin
      frame_begin_trigger <= 1'b0;
      acquisition_begin_trigger <= 1'b0;
      line_begin_trigger <= 1'b0;
    end else begin
      frame_begin_trigger <= next_frame_trig;
      acquisition_begin_trigger <= next_acq_trig;
      line_begin_trigger <= next_line_trig;
    end
  end

  // ----------------------------------------
  // frame counter
  // ----------------------------------------
  wire logic [CNT_W-1:0] next_frame_count;

  // reset wins over a coincident frame completion; the count wraps silently
  assign next_frame_count = do_cnt_reset ? '0 :
    (frame_done ? frame_count + CNT_W'(1) : frame_count); // R14

  always_ff @(posedge mclk) begin
    if (rst) begin
      frame_count <= '0;
    end else begin
      frame_count <= next_frame_count; // R14
    end
  end
endmodule : bacf_filter

`default_nettype wire

// file: dv/bacf_filter_assertions.sv
/* checker for the action filter ports.
   assumes bind with every port matched by name. */
`timescale 1ns/1ps
`default_nettype none
module bacf_filter_chk (
  // clock, reset, strobes
  input wire logic mclk, rst, msg_valid, busy, cfg_we,
  // routing and outputs
  input wire logic action_pulse, trigger_from_action, counter_reset_from_action,
  input wire logic frame_begin_trigger, acquisition_begin_trigger, line_begin_trigger,
  input wire logic [1:0] trigger_select,
  // wide values
  input wire logic [31:0] num_action_signals, action_slot_select, cfg_group_key,
  input wire logic [31:0] group_match_key, frame_count
);
  default clocking @(posedge mclk); endclocking
  default disable iff (rst);
  sequence s_take;
    msg_valid && !busy;
  endsequence
  // a hit keeps busy up through the fire state, a miss drops it after the compare
  sequence s_hit;
    s_take ##1 busy ##1 busy;
  endsequence
  sequence s_miss;
    s_take ##1 busy ##1 !busy;
  endsequence
  a_pulse_cause: assert property (action_pulse |-> $past(msg_valid, 3) && !$past(busy, 3))
    else $error("pulse without a taken message");
  a_hit_fire: assert property (s_hit |=> action_pulse)
    else $error("hit did not fire");
  a_miss_quiet: assert property (s_miss |=> !action_pulse)
    else $error("miss fired");
  a_pulse_once: assert property (action_pulse |=> !action_pulse)
    else $error("pulse longer than one cycle");
  a_one_signal: assert property (num_action_signals == 32'h1)
    else $error("signal count not one");
  a_frame_trig: assert property (
    frame_begin_trigger == (action_pulse && $past(trigger_from_action)
    && $past(trigger_select) == 2'h0))
    else $error("frame trigger wrong");
  a_acq_trig: assert property (
    acquisition_begin_trigger == (action_pulse && $past(trigger_from_action)
    && $past(trigger_select) == 2'h1))
    else $error("acquisition trigger wrong");
  a_line_trig: assert property (
    line_begin_trigger == (action_pulse && $past(trigger_from_action)
    && $past(trigger_select) == 2'h2))
    else $error("line trigger wrong");
  a_cnt_clear: assert property (
    action_pulse && $past(counter_reset_from_action) |-> frame_count == 32'h0)
    else $error("frame count not cleared");
  a_cfg_take: assert property (cfg_we && action_slot_select == 32'h1
    |=> group_match_key == $past(cfg_group_key))
    else $error("group key not stored");
  a_take_busy: assert property (s_take |=> busy)
    else $error("busy not raised");
endmodule : bacf_filter_chk
`default_nettype wire

// file: dv/bacf_host.sv
/* host model sending broadcast action messages.
   assumes the bench calls send only when the filter is idle. */
`timescale 1ns/1ps
`default_nettype none
module bacf_host (
  // clock
  input wire logic mclk,
  // message
  output logic msg_valid,
  output logic [31:0] msg_auth_key,
  output logic [31:0] msg_group_key,
  output logic [31:0] msg_subgroup_mask
);
  // all-ones destination reaches every listener on the segment
  localparam logic [31:0] DEST_ALL = 32'hffff_ffff;
  logic [31:0] last_dest = '0;
  initial {msg_valid, msg_auth_key, msg_group_key, msg_subgroup_mask} = '0;
  // one message reaches every listener
  task automatic send(input logic [31:0] a, g, m);
    @(posedge mclk) #1;
    last_dest = DEST_ALL;
    {msg_valid, msg_auth_key, msg_group_key, msg_subgroup_mask} = {1'b1, a, g, m};
    @(posedge mclk) #1;
    msg_valid = 1'b0;
    // stale fields would hide a sampling slip
    {msg_auth_key, msg_group_key, msg_subgroup_mask} = ~{a, g, m};
  endtask : send
endmodule : bacf_host
`default_nettype wire

// file: dv/bacf_filter_bench.sv
/* self-checking bench for the action filter.
   assumes the host model and the bound checker. */
`timescale 1ns/1ps
`default_nettype none
module bacf_filter_bench;
  logic mclk, rst, cfg_we, trigger_from_action, counter_reset_from_action, frame_done;
  logic msg_valid, busy, action_pulse, frame_begin_trigger, acquisition_begin_trigger;
  logic line_begin_trigger;
  logic [1:0] trigger_select;
  logic [31:0] action_slot_select, cfg_auth_key, cfg_group_key, cfg_subgroup_mask, n;
  logic [31:0] msg_auth_key, msg_group_key, msg_subgroup_mask, num_action_signals;
  logic [31:0] group_match_key, subgroup_mask, frame_count;
  int mismatches = 0;
  int total_checks = 0;
  bacf_filter bacf_filter_i (.*);
  bacf_host bacf_host_i (.*);
  task automatic chk(input logic [31:0] got, exp);
    total_checks++;
    if (got !== exp) begin
      mismatches++;
      $display("[FAIL] %0t got %h exp %h", $time, got, exp);
    end
  endtask : chk
  task automatic cfg(input logic [31:0] s, a, g, m);
    @(posedge mclk) #1;
    {action_slot_select, cfg_auth_key, cfg_group_key, cfg_subgroup_mask} = {s, a, g, m};
    cfg_we = 1'b1;
    @(posedge mclk) #1;
    cfg_we = 1'b0;
  endtask : cfg
  // n gathers pulse and the three triggers seen in the answer window
  task automatic msg(input logic [31:0] a, g, m);
    n = '0;
    bacf_host_i.send(a, g, m);
    repeat (4) begin
      @(posedge mclk) #1;
      n |= {action_pulse, frame_begin_trigger, acquisition_begin_trigger, line_begin_trigger};
    end
  endtask : msg
  task automatic final_report;
    if (mismatches == 0 && total_checks > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask : final_report
  initial begin
    mclk = 1'b0;
    forever #25 mclk = ~mclk;
  end
  initial begin
    repeat (2000) @(posedge mclk);
    mismatches++;
    final_report();
  end
  task automatic t_idle_state;
    chk(num_action_signals, 32'h1);
    chk(frame_count, 32'h0);
  endtask : t_idle_state
  // a write to any slot but one is dropped; slot one replaces all fields
  task automatic t_config;
    cfg(32'h2, 32'h1267, 32'h1, 32'h2c);
    chk(group_match_key, 32'h0);
    cfg(32'h1, 32'h1267, 32'h1, 32'h2c);
    chk({group_match_key ^ subgroup_mask}, 32'h2d);
  endtask : t_config
  task automatic t_match;
    msg(32'h1267, 32'h1, 32'h4);
    chk(n, 32'hc);
    chk(bacf_host_i.last_dest, 32'hffff_ffff);
  endtask : t_match
  task automatic t_miss;
    msg(32'h1266, 32'h1, 32'h4);
    chk(n, 32'h0);
    msg(32'h1267, 32'h3, 32'h4);
    chk(n, 32'h0);
    msg(32'h1267, 32'h1, 32'hffff_ffd3);
    chk(n, 32'h0);
  endtask : t_miss
  // select 3 routes to no trigger; routing off leaves only the pulse
  task automatic t_routing;
    for (int s = 0; s < 4; s++) begin
      trigger_select = s[1:0];
      msg(32'h1267, 32'h1, 32'h8);
      chk(n, 32'h8 | (32'h4 >> s));
    end
    trigger_select = 2'h0;
    trigger_from_action = 1'b0;
    msg(32'h1267, 32'h1, 32'h8);
    chk(n, 32'h8);
    trigger_from_action = 1'b1;
  endtask : t_routing
  task automatic t_counter;
    counter_reset_from_action = 1'b1;
    repeat (3) begin
      @(posedge mclk) #1 frame_done = 1'b1;
      @(posedge mclk) #1 frame_done = 1'b0;
    end
    chk(frame_count, 32'h3);
    msg(32'h1267, 32'h1, 32'h20);
    chk(frame_count, 32'h0);
    counter_reset_from_action = 1'b0;
    @(posedge mclk) #1 frame_done = 1'b1;
    @(posedge mclk) #1 frame_done = 1'b0;
    msg(32'h1267, 32'h1, 32'h20);
    chk(frame_count, 32'h1);
  endtask : t_counter
  task automatic t_overwrite;
    cfg(32'h1, 32'h55aa, 32'h7, 32'h3);
    msg(32'h1267, 32'h1, 32'h1);
    chk(n, 32'h0);
    msg(32'h55aa, 32'h7, 32'h2);
    chk(n, 32'hc);
  endtask : t_overwrite
  // a mid-run reset clears the slot, so the last keys no longer match
  task automatic t_reset_mid;
    @(posedge mclk) #1 rst = 1'b1;
    repeat (2) @(posedge mclk);
    #1 rst = 1'b0;
    chk(group_match_key, 32'h0);
    chk(subgroup_mask, 32'h0);
    chk(frame_count, 32'h0);
    msg(32'h55aa, 32'h7, 32'h2);
    chk(n, 32'h0);
  endtask : t_reset_mid
  initial begin
    {rst, trigger_from_action} = 2'h3;
    {cfg_we, frame_done, counter_reset_from_action, trigger_select} = '0;
    {action_slot_select, cfg_auth_key, cfg_group_key, cfg_subgroup_mask} = '0;
    repeat (4) @(posedge mclk);
    #1 rst = 1'b0;
    t_idle_state();
    t_config();
    t_match();
    t_miss();
    t_routing();
    t_counter();
    t_overwrite();
    t_reset_mid();
    final_report();
  end
endmodule : bacf_filter_bench
bind bacf_filter bacf_filter_chk bacf_filter_chk_i (.*);
`default_nettype wire
